// *** inc/wcpb_pkg.sv ***
/*
 * Constants shared by the winding current bridge controller.
 * Assumes a 125 MHz system clock and an APB register bus with 12-bit addresses.
 */
package wcpb_pkg;
    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int LVL_W   = 4;
    localparam int PIN_W   = 5;
    localparam int DEM_W   = 12;
    localparam int TRI_W   = 11;
    localparam int MID_W   = 10;
    localparam int GAIN_W  = 3;
    localparam int ADDR_W  = 12;
    localparam int ACC_W   = 14;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_CTRL  = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_MID   = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_STAT  = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_SENSE = 12'h00c;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_EN_POS   = 0;
    localparam int CTRL_GAIN_LSB = 1;
    localparam int STAT_ERR_LSB  = 0;
    localparam int STAT_LVL_LSB  = 16;
    localparam int STAT_DIR_POS  = 20;
    localparam int STAT_A_POS    = 21;
    localparam int STAT_B_POS    = 22;
    localparam int SENSE_DEM_LSB = 16;

    // ------------------------------------------------------------
    // Values after reset and the midpoint minimum
    // ------------------------------------------------------------
    localparam logic             EN_RST   = 1'b0;
    localparam logic [GAIN_W-1:0] GAIN_RST = 3'h3;
    localparam logic [MID_W-1:0]  MID_RST  = 10'h1f4;
    localparam logic [MID_W-1:0]  MID_MIN  = 10'h001;

    // ------------------------------------------------------------
    // Level table, tenths of a percent of full scale, active-high code
    // ------------------------------------------------------------
    localparam logic [9:0] LEVEL_TABLE [16] = '{
        10'h000, 10'h05f, 10'h0bf, 10'h11e, 10'h17d, 10'h1dc, 10'h22c, 10'h27b,
        10'h2ca, 10'h30a, 10'h339, 10'h379, 10'h399, 10'h3b8, 10'h3d8, 10'h3e8
    };
endpackage

// *** hw/wcpb_tri_counter.sv ***
/*
 * Up/down counter forming one triangle reference.
 * Assumes top is at least one and that restart pulses when top changes.
 */
`timescale 1ns/1ns
`default_nettype none
module wcpb_tri_counter #(
    parameter int  W          = 11,
    parameter bit  START_HIGH = 1'b0
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         restart,
    input  wire logic [W-1:0] top,
    output logic      [W-1:0] count
);
    logic goingUp_r;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count     <= '0;
            goingUp_r <= 1'b1;
        end else if (restart) begin
            count     <= START_HIGH ? top : '0;
            goingUp_r <= !START_HIGH;
        end else if (goingUp_r) begin
            if (count >= top - 1'b1) begin
                count     <= top;
                goingUp_r <= 1'b0;
            end else begin
                count <= count + 1'b1;
            end
        end else begin
            if (count <= 1) begin
                count     <= '0;
                goingUp_r <= 1'b1;
            end else begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/wcpb_bridge_ctrl.sv ***
/*
 * One winding channel: level decode, signed demand, digital error loop,
 * two phase-shifted triangle references and the two half-bridge drives.
 * Assumes level and direction pins are asynchronous, sensed current comes
 * signed on the system clock, and software uses APB.
 */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ns
`default_nettype none
module wcpb_bridge_ctrl (
    input  wire logic                                clk,
    input  wire logic                                rst_n,
    input  wire logic                                levelSelectBit0_n,
    input  wire logic                                levelSelectBit1_n,
    input  wire logic                                levelSelectBit2_n,
    input  wire logic                                levelSelectBit3_n,
    input  wire logic                                currentDirectionInput,
    input  wire logic signed [wcpb_pkg::DEM_W-1:0]   senseCurrent,
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic        [wcpb_pkg::ADDR_W-1:0]  paddr,
    input  wire logic        [31:0]                  pwdata,
    output logic             [31:0]                  prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    output logic                                     bridgeAHighOn,
    output logic                                     bridgeALowOn,
    output logic                                     bridgeBHighOn,
    output logic                                     bridgeBLowOn
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [wcpb_pkg::PIN_W-1:0]         pinRaw;
    logic [wcpb_pkg::PIN_W-1:0]         syncA_r;
    logic [wcpb_pkg::PIN_W-1:0]         syncB_r;
    logic [wcpb_pkg::PIN_W-1:0]         syncC_r;
    logic [wcpb_pkg::PIN_W-1:0]         pinStable_r;
    logic [wcpb_pkg::LVL_W-1:0]         levelCode;
    logic                               dirPositive;
    logic [9:0]                         levelFrac;
    logic signed [wcpb_pkg::DEM_W-1:0]  demand_r;
    logic                               enable_r;
    logic [wcpb_pkg::GAIN_W-1:0]        gainShift_r;
    logic [wcpb_pkg::MID_W-1:0]         midRef_r;
    logic [wcpb_pkg::TRI_W-1:0]         triTop;
    logic                               restart_r;
    logic [wcpb_pkg::TRI_W-1:0]         triInPhase;
    logic [wcpb_pkg::TRI_W-1:0]         triShifted;
    logic [wcpb_pkg::TRI_W-1:0]         errValue_r;
    logic signed [wcpb_pkg::ACC_W-1:0]  diff;
    logic signed [wcpb_pkg::ACC_W-1:0]  step;
    logic signed [wcpb_pkg::ACC_W-1:0]  errSum;
    logic [wcpb_pkg::TRI_W-1:0]         errValue_nxt;
    logic                               driveA_r;
    logic                               driveB_r;
    logic                               apbAccess;
    logic                               apbDone;
    logic                               apbWrite;
    logic                               addrMapped;
    logic [31:0]                        readMux;
    logic [wcpb_pkg::MID_W-1:0]         midWrite;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    assign pinRaw = {currentDirectionInput, levelSelectBit3_n, levelSelectBit2_n,
                     levelSelectBit1_n, levelSelectBit0_n};

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            syncA_r <= '1;
            syncB_r <= '1;
            syncC_r <= '1;
        end else begin
            syncA_r <= pinRaw;
            syncB_r <= syncA_r;
            syncC_r <= syncB_r;
        end
    end

    // Accept a pin change once two stages agree
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pinStable_r <= '1;
        end else begin
            for (int i = 0; i < wcpb_pkg::PIN_W; i++) begin
                if (syncB_r[i] == syncC_r[i]) begin
                    pinStable_r[i] <= syncC_r[i];
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Level decode and signed demand
    // ------------------------------------------------------------
    assign levelCode   = ~pinStable_r[wcpb_pkg::LVL_W-1:0];
    assign dirPositive = pinStable_r[wcpb_pkg::LVL_W];
    assign levelFrac   = wcpb_pkg::LEVEL_TABLE[levelCode];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            demand_r <= '0;
        end else if (dirPositive) begin
            demand_r <= $signed({2'b00, levelFrac});
        end else begin
            demand_r <= -$signed({2'b00, levelFrac});
        end
    end

    // ------------------------------------------------------------
    // Triangle references
    // ------------------------------------------------------------
    assign triTop = {midRef_r, 1'b0};

    wcpb_tri_counter #(
        .W          (wcpb_pkg::TRI_W),
        .START_HIGH (1'b0)
    ) uTriInPhase (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (restart_r),
        .top     (triTop),
        .count   (triInPhase)
    );

    wcpb_tri_counter #(
        .W          (wcpb_pkg::TRI_W),
        .START_HIGH (1'b1)
    ) uTriShifted (
        .clk     (clk),
        .rst_n   (rst_n),
        .restart (restart_r),
        .top     (triTop),
        .count   (triShifted)
    );

    // ------------------------------------------------------------
    // Error loop
    // ------------------------------------------------------------
    function automatic logic signed [wcpb_pkg::ACC_W-1:0] ACC_EXT(
        input logic signed [wcpb_pkg::DEM_W-1:0] v
    );
        ACC_EXT = {{(wcpb_pkg::ACC_W-wcpb_pkg::DEM_W){v[wcpb_pkg::DEM_W-1]}}, v};
    endfunction

    always_comb begin
        diff   = ACC_EXT(demand_r) - ACC_EXT(senseCurrent);
        step   = diff >>> gainShift_r;
        errSum = $signed({3'b000, errValue_r}) + step;
        if (errSum < 0) begin
            errValue_nxt = '0;
        end else if (errSum > $signed({3'b000, triTop})) begin
            errValue_nxt = triTop;
        end else begin
            errValue_nxt = errSum[wcpb_pkg::TRI_W-1:0];
        end
    end

    // Loop parks at midpoint while disabled or on period change
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            errValue_r <= {wcpb_pkg::MID_RST, 1'b0} >> 1;
        end else if (!enable_r || restart_r) begin
            errValue_r <= {1'b0, midRef_r};
        end else begin
            errValue_r <= errValue_nxt;
        end
    end

    // ------------------------------------------------------------
    // Duty comparators
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            driveA_r <= 1'b0;
            driveB_r <= 1'b0;
        end else begin
            // Mirrored triangles give equal and opposite deviation
            driveA_r <= errValue_r > triInPhase;
            driveB_r <= triShifted > errValue_r;
        end
    end

    // ------------------------------------------------------------
    // Half-bridge drive
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bridgeAHighOn <= 1'b0;
            bridgeALowOn  <= 1'b0;
            bridgeBHighOn <= 1'b0;
            bridgeBLowOn  <= 1'b0;
        end else if (!enable_r) begin
            bridgeAHighOn <= 1'b0;
            bridgeALowOn  <= 1'b0;
            bridgeBHighOn <= 1'b0;
            bridgeBLowOn  <= 1'b0;
        end else begin
            bridgeAHighOn <= driveA_r;
            bridgeALowOn  <= !driveA_r;
            bridgeBHighOn <= driveB_r;
            bridgeBLowOn  <= !driveB_r;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    assign apbAccess  = psel && penable;
    assign apbDone    = apbAccess && pready;
    assign apbWrite   = apbDone && pwrite && !pslverr;
    assign addrMapped = (paddr == wcpb_pkg::ADDR_CTRL) || (paddr == wcpb_pkg::ADDR_MID) ||
                        (paddr == wcpb_pkg::ADDR_STAT) || (paddr == wcpb_pkg::ADDR_SENSE);
    assign midWrite   = pwdata[wcpb_pkg::MID_W-1:0];

    always_comb begin
        readMux = '0;
        case (paddr)
            wcpb_pkg::ADDR_CTRL: begin
                readMux[wcpb_pkg::CTRL_EN_POS] = enable_r;
                readMux[wcpb_pkg::CTRL_GAIN_LSB +: wcpb_pkg::GAIN_W] = gainShift_r;
            end
            wcpb_pkg::ADDR_MID: begin
                readMux[wcpb_pkg::MID_W-1:0] = midRef_r;
            end
            wcpb_pkg::ADDR_STAT: begin
                readMux[wcpb_pkg::STAT_ERR_LSB +: wcpb_pkg::TRI_W] = errValue_r;
                readMux[wcpb_pkg::STAT_LVL_LSB +: wcpb_pkg::LVL_W] = levelCode;
                readMux[wcpb_pkg::STAT_DIR_POS] = dirPositive;
                readMux[wcpb_pkg::STAT_A_POS]   = driveA_r;
                readMux[wcpb_pkg::STAT_B_POS]   = driveB_r;
            end
            wcpb_pkg::ADDR_SENSE: begin
                readMux[wcpb_pkg::DEM_W-1:0] = senseCurrent;
                readMux[wcpb_pkg::SENSE_DEM_LSB +: wcpb_pkg::DEM_W] = demand_r;
            end
            default: begin
                readMux = '0;
            end
        endcase
    end

    // One wait state: ready rises in the second access cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= '0;
        end else if (apbAccess && !pready) begin
            pready  <= 1'b1;
            pslverr <= !addrMapped;
            prdata  <= (pwrite || !addrMapped) ? 32'h0000_0000 : readMux;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_r    <= wcpb_pkg::EN_RST;
            gainShift_r <= wcpb_pkg::GAIN_RST;
        end else if (apbWrite && paddr == wcpb_pkg::ADDR_CTRL) begin
            enable_r    <= pwdata[wcpb_pkg::CTRL_EN_POS];
            gainShift_r <= pwdata[wcpb_pkg::CTRL_GAIN_LSB +: wcpb_pkg::GAIN_W];
        end
    end

    // Midpoint sets the triangle half period
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            midRef_r  <= wcpb_pkg::MID_RST;
            restart_r <= 1'b1;
        end else if (apbWrite && paddr == wcpb_pkg::ADDR_MID) begin
            midRef_r  <= (midWrite < wcpb_pkg::MID_MIN) ? wcpb_pkg::MID_MIN : midWrite;
            restart_r <= 1'b1;
        end else begin
            restart_r <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// *** tb/wcpb_bridge_ctrl_properties.sv ***
/* Port checker for the winding bridge controller.
   Bound to wcpb_bridge_ctrl; sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module wcpb_bridge_ctrl_props (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        bridgeAHighOn,
    input wire logic        bridgeALowOn,
    input wire logic        bridgeBHighOn,
    input wire logic        bridgeBLowOn
);
    // ------------------------------------------------------------
    // Enable tracking
    // ------------------------------------------------------------
    logic ctrlEn_r;
    logic mapped;
    assign mapped = (paddr == wcpb_pkg::ADDR_CTRL) || (paddr == wcpb_pkg::ADDR_MID)
                 || (paddr == wcpb_pkg::ADDR_STAT) || (paddr == wcpb_pkg::ADDR_SENSE);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlEn_r <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == wcpb_pkg::ADDR_CTRL) begin
            ctrlEn_r <= pwdata[wcpb_pkg::CTRL_EN_POS];
        end
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_no_crossfire: assert property (
        !(bridgeAHighOn && bridgeALowOn) && !(bridgeBHighOn && bridgeBLowOn))
        else $error("half bridge shorted");
    a_off_quiet: assert property (
        !ctrlEn_r [*4] |-> !(bridgeAHighOn || bridgeALowOn || bridgeBHighOn || bridgeBLowOn))
        else $error("bridge driven while disabled");
    a_pair_a: assert property (ctrlEn_r [*4] |-> bridgeAHighOn != bridgeALowOn)
        else $error("bridge A not complementary");
    a_pair_b: assert property (ctrlEn_r [*4] |-> bridgeBHighOn != bridgeBLowOn)
        else $error("bridge B not complementary");
    a_ready_timing: assert property (psel && !penable ##1 psel && penable |=> pready)
        else $error("pready late");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("pready outside access");
    a_slverr_map: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr wrong for address");
    a_err_zero: assert property (pready && pslverr |-> prdata == 32'h0 && !$past(pready))
        else $error("error read data not zero");
    a_err_alone: assert property (!pready |-> !pslverr)
        else $error("pslverr without pready");
    c_ctrl_write: cover property (pready && pwrite && paddr == wcpb_pkg::ADDR_CTRL);
    c_slverr: cover property (pready && pslverr);
    c_a_rise: cover property ($rose(bridgeAHighOn));
    c_b_rise: cover property ($rose(bridgeBHighOn));
endmodule
bind wcpb_bridge_ctrl wcpb_bridge_ctrl_props u_props (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bridgeAHighOn(bridgeAHighOn),
    .bridgeALowOn(bridgeALowOn), .bridgeBHighOn(bridgeBHighOn), .bridgeBLowOn(bridgeBLowOn));
`default_nettype wire

// *** tb/wcpb_pin_driver.sv ***
/* Step sequencer model driving the level, direction and sense inputs.
   Assumes the bench sets the wanted values; pins change after rising edges. */
`timescale 1ns/1ns
`default_nettype none
module wcpb_pin_driver (
    input  wire logic               clk,
    input  wire logic               rst_n,
    input  wire logic [3:0]         codeSet,
    input  wire logic               dirSet,
    input  wire logic signed [11:0] senseSet,
    output logic [3:0]              levelPins_n,
    output logic                    dirPin,
    output logic signed [11:0]      senseCurrent
);
    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            levelPins_n  <= 4'hf;
            dirPin       <= 1'b1;
            senseCurrent <= 12'sh000;
        end else begin
            levelPins_n  <= ~codeSet;
            dirPin       <= dirSet;
            senseCurrent <= senseSet;
        end
    end
endmodule
`default_nettype wire

// *** tb/test_winding_current_pwm_bridge_control.sv ***
/* Self-checking bench for the winding bridge controller.
   Assumes wcpb_pkg, the pin driver model and the bound checker are compiled. */
`timescale 1ns/1ns
`default_nettype none
module test_winding_current_pwm_bridge_control;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, se, aHi, aLo, bHi, bLo, dirPin, dirSet = 1'b1, prevA;
    logic [3:0]  codeSet = 4'h0, pins_n;
    logic signed [11:0] senseSet = 12'sh000, senseCur;
    int errors = 0, comparisons = 0, cycles = 0, ca, cb, cd, cr, cl;
    always #4 clk = ~clk;
    wcpb_pin_driver u_drv (.clk(clk), .rst_n(rst_n), .codeSet(codeSet), .dirSet(dirSet),
        .senseSet(senseSet), .levelPins_n(pins_n), .dirPin(dirPin), .senseCurrent(senseCur));
    wcpb_bridge_ctrl u_dut (.clk(clk), .rst_n(rst_n), .levelSelectBit0_n(pins_n[0]),
        .levelSelectBit1_n(pins_n[1]), .levelSelectBit2_n(pins_n[2]),
        .levelSelectBit3_n(pins_n[3]), .currentDirectionInput(dirPin),
        .senseCurrent(senseCur), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .bridgeAHighOn(aHi), .bridgeALowOn(aLo),
        .bridgeBHighOn(bHi), .bridgeBLowOn(bLo));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic stop_test;
        if (errors == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] act, input logic [31:0] exp);
        comparisons++;
        if (act !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic check_near(input int act, input int exp, input int tol);
        comparisons++;
        if (act > exp + tol || act < exp - tol) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, act, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdmask(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e,
                          input logic err);
        apb(1'b0, a, 32'h0);
        check_word(rd & m, e);
        check_word({31'h0, se}, {31'h0, err});
    endtask
    task automatic set_pins(input logic [3:0] c, input logic d, input logic signed [11:0] s);
        @(posedge clk);
        codeSet <= c;
        dirSet <= d;
        senseSet <= s;
        repeat (12) @(posedge clk);
    endtask
    task automatic measure(input int n);
        ca = 0;
        cb = 0;
        cd = 0;
        cr = 0;
        cl = 0;
        #1;
        prevA = aHi;
        repeat (n) begin
            @(posedge clk);
            #1;
            ca += int'(aHi === 1'b1);
            cb += int'(bHi === 1'b1);
            cd += int'(aHi !== bHi);
            cr += int'(aHi === 1'b1 && prevA === 1'b0);
            cl += int'(aLo !== ~aHi) + int'(bLo !== ~bHi);
            prevA = aHi;
        end
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            stop_test();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [11:0] dem;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rdmask(wcpb_pkg::ADDR_CTRL, 32'hf, 32'h6, 1'b0);
        rdmask(wcpb_pkg::ADDR_MID, 32'h3ff, 32'(wcpb_pkg::MID_RST), 1'b0);
        rdmask(12'h010, 32'hffffffff, 32'h0, 1'b1);
        apb(1'b1, wcpb_pkg::ADDR_SENSE, 32'hffffffff);
        rdmask(wcpb_pkg::ADDR_SENSE, 32'hffffffff, 32'h0, 1'b0);
        apb(1'b1, wcpb_pkg::ADDR_MID, 32'h0);
        rdmask(wcpb_pkg::ADDR_MID, 32'h3ff, 32'(wcpb_pkg::MID_MIN), 1'b0);
        for (int d = 0; d < 2; d++) begin
            for (int c = 0; c < 16; c++) begin
                set_pins(4'(c), d[0], 12'sh000);
                dem = {2'b00, wcpb_pkg::LEVEL_TABLE[c]};
                if (d == 0) dem = -dem;
                rdmask(wcpb_pkg::ADDR_SENSE, 32'h0fff0000,
                       {4'h0, dem, 16'h0}, 1'b0);
                rdmask(wcpb_pkg::ADDR_STAT, 32'h001f0000,
                       {11'h0, d[0], 4'(c), 16'h0}, 1'b0);
            end
        end
        set_pins(4'h0, 1'b1, 12'sh000);
        apb(1'b1, wcpb_pkg::ADDR_CTRL, 32'h7);
        for (int m = 20; m >= 10; m -= 10) begin
            apb(1'b1, wcpb_pkg::ADDR_MID, 32'(m));
            repeat (3) @(posedge clk);
            measure(160);
            check_near(cd, 0, 0);
            check_near(ca, 80, 4);
            check_near(cr, 160 / (4 * m), 0);
            check_near(cl, 0, 0);
            rdmask(wcpb_pkg::ADDR_STAT, 32'h7ff, 32'(m), 1'b0);
        end
        set_pins(4'h1, 1'b1, 12'sh05f);
        apb(1'b1, wcpb_pkg::ADDR_MID, 32'd20);
        repeat (40) @(posedge clk);
        rdmask(wcpb_pkg::ADDR_STAT, 32'h7ff, 32'd20, 1'b0);
        set_pins(4'h1, 1'b1, 12'sh000);
        rdmask(wcpb_pkg::ADDR_STAT, 32'h7ff, 32'd40, 1'b0);
        measure(80);
        check_near(ca, 80, 2);
        check_near(cb, 0, 1);
        check_near(ca + cb, 80, 2);
        check_near(cl, 0, 0);
        set_pins(4'h1, 1'b0, 12'sh000);
        rdmask(wcpb_pkg::ADDR_STAT, 32'h7ff, 32'd0, 1'b0);
        measure(80);
        check_near(ca, 0, 1);
        check_near(cb, 80, 2);
        apb(1'b1, wcpb_pkg::ADDR_CTRL, 32'h6);
        repeat (4) @(posedge clk);
        measure(80);
        check_near(ca + cb, 0, 0);
        check_near(cl, 160, 0);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rdmask(wcpb_pkg::ADDR_CTRL, 32'hf, 32'h6, 1'b0);
        rdmask(wcpb_pkg::ADDR_MID, 32'h3ff, 32'(wcpb_pkg::MID_RST), 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
